/* File: core/cmpreg_flag.sv */
// sticky edge flag where hardware set wins over software clear
`timescale 1ns/1ps
module cmpreg_flag
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic set,
    input wire logic wr,
    input wire logic wval,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    always_comb
    begin
        flag_nxt = flag_r;
        if (wr)
            flag_nxt = wval;
        if (set)
            flag_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

    assign flag = flag_r;

    property p_flag_set;
        @(posedge clk) disable iff (!nrst) set |=> flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("edge lost in flag");

    property p_flag_hold;
        @(posedge clk) disable iff (!nrst) (flag && !wr) |=> flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without write");
endmodule : cmpreg_flag

/* File: core/cmpreg_sync.sv */
// two-flop synchroniser with edge detection for one comparator output
`timescale 1ns/1ps
module cmpreg_sync
    import cmpreg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic raw,
    input wire logic en,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } cmpreg_sync_st_t;

    cmpreg_sync_st_t st_r;
    cmpreg_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = raw & en;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign level = st_r.s2;
    assign rise = st_r.s2 & ~st_r.prev;
    assign fall = ~st_r.s2 & st_r.prev;

    property p_sync_rise;
        @(posedge clk) disable iff (!nrst) rise |-> $past(st_r.s1) && !$past(st_r.s1, 2);
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("rise not from synchronised edge");
endmodule : cmpreg_sync

/* File: core/cmpreg_top.sv */
// control and status registers for two comparators on the sfr bus
`timescale 1ns/1ps
module cmpreg_top
    import cmpreg_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_PAGE,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic CMP_A_RAW,
    input wire logic CMP_B_RAW,
    input wire logic CMP_A_SRC_IE,
    input wire logic CMP_B_SRC_IE,
    input wire logic GLOBAL_IE,
    output logic CMP_A_ENABLE,
    output logic CMP_B_ENABLE,
    output logic [1:0] CMP_A_POS_HYST,
    output logic [1:0] CMP_A_NEG_HYST,
    output logic [1:0] CMP_B_POS_HYST,
    output logic [1:0] CMP_B_NEG_HYST,
    output logic [1:0] CMP_A_RESPONSE_MODE,
    output logic CMP_A_LATCHED_OUTPUT,
    output logic CMP_B_LATCHED_OUTPUT,
    output logic CMP_A_IRQ,
    output logic CMP_B_IRQ
);
    import cmpreg_pkg::*;

    typedef struct packed {
        logic a_en;
        logic [1:0] a_hyp;
        logic [1:0] a_hyn;
        logic b_en;
        logic [1:0] b_hyp;
        logic [1:0] b_hyn;
        cmpreg_mode_t a_mode;
        logic [7:0] rdata;
        logic a_lat;
        logic b_lat;
        logic a_irq;
        logic b_irq;
    } cmpreg_top_st_t;

    cmpreg_top_st_t st_r;
    cmpreg_top_st_t st_nxt;
    cmpreg_bus_t bus;

    logic sel_a_ctrl;
    logic sel_b_ctrl;
    logic sel_a_mode;
    logic a_level;
    logic a_rise_ev;
    logic a_fall_ev;
    logic b_level;
    logic b_rise_ev;
    logic b_fall_ev;
    logic a_rise_flag;
    logic a_fall_flag;
    logic b_rise_flag;
    logic b_fall_flag;
    cmpreg_ctrl_t a_view;
    cmpreg_ctrl_t b_view;

    // address decode, checked against page CMPREG_PAGE_CTRL only for paged registers
    function automatic logic hit(input cmpreg_bus_t b, input logic [7:0] a, input logic paged);
        hit = (b.addr == a) && (!paged || b.page == CMPREG_PAGE_CTRL);
    endfunction : hit

    // control register image from fields
    function automatic logic [7:0] ctrl_byte(input cmpreg_ctrl_t c);
        ctrl_byte = {c.en, c.out, c.rise, c.fall, c.hyp, c.hyn};
    endfunction : ctrl_byte

    assign bus = '{addr: SFR_ADDR, page: SFR_PAGE, wdata: SFR_WDATA, wr: SFR_WR};
    assign sel_a_ctrl = hit(bus, CMPREG_ADDR_A_CTRL, 1'b1);
    assign sel_b_ctrl = hit(bus, CMPREG_ADDR_B_CTRL, 1'b1);
    assign sel_a_mode = hit(bus, CMPREG_ADDR_A_MODE, 1'b0);

    cmpreg_sync u_sync_a (
        .clk(CLK),
        .nrst(NRST),
        .raw(CMP_A_RAW),
        .en(st_r.a_en),
        .level(a_level),
        .rise(a_rise_ev),
        .fall(a_fall_ev)
    );

    cmpreg_sync u_sync_b (
        .clk(CLK),
        .nrst(NRST),
        .raw(CMP_B_RAW),
        .en(st_r.b_en),
        .level(b_level),
        .rise(b_rise_ev),
        .fall(b_fall_ev)
    );

    cmpreg_flag u_a_rise (
        .clk(CLK),
        .nrst(NRST),
        .set(a_rise_ev),
        .wr(SFR_WR && sel_a_ctrl),
        .wval(SFR_WDATA[CMPREG_BIT_RISE]),
        .flag(a_rise_flag)
    );

    cmpreg_flag u_a_fall (
        .clk(CLK),
        .nrst(NRST),
        .set(a_fall_ev),
        .wr(SFR_WR && sel_a_ctrl),
        .wval(SFR_WDATA[CMPREG_BIT_FALL]),
        .flag(a_fall_flag)
    );

    cmpreg_flag u_b_rise (
        .clk(CLK),
        .nrst(NRST),
        .set(b_rise_ev),
        .wr(SFR_WR && sel_b_ctrl),
        .wval(SFR_WDATA[CMPREG_BIT_RISE]),
        .flag(b_rise_flag)
    );

    cmpreg_flag u_b_fall (
        .clk(CLK),
        .nrst(NRST),
        .set(b_fall_ev),
        .wr(SFR_WR && sel_b_ctrl),
        .wval(SFR_WDATA[CMPREG_BIT_FALL]),
        .flag(b_fall_flag)
    );

    assign a_view = '{en: st_r.a_en, out: a_level, rise: a_rise_flag, fall: a_fall_flag,
                      hyp: st_r.a_hyp, hyn: st_r.a_hyn};
    assign b_view = '{en: st_r.b_en, out: b_level, rise: b_rise_flag, fall: b_fall_flag,
                      hyp: st_r.b_hyp, hyn: st_r.b_hyn};

    always_comb
    begin
        st_nxt = st_r;
        if (SFR_WR && sel_a_ctrl)
        begin
            st_nxt.a_en = SFR_WDATA[CMPREG_BIT_EN];
            st_nxt.a_hyp = SFR_WDATA[3:2];
            st_nxt.a_hyn = SFR_WDATA[1:0];
        end
        if (SFR_WR && sel_b_ctrl)
        begin
            st_nxt.b_en = SFR_WDATA[CMPREG_BIT_EN];
            st_nxt.b_hyp = SFR_WDATA[3:2];
            st_nxt.b_hyn = SFR_WDATA[1:0];
        end
        if (SFR_WR && sel_a_mode)
        begin
            st_nxt.a_mode.rise_ie = SFR_WDATA[5];
            st_nxt.a_mode.fall_ie = SFR_WDATA[4];
            st_nxt.a_mode.md = SFR_WDATA[1:0];
        end
        st_nxt.rdata = 8'h00;
        if (SFR_RD)
        begin
            if (sel_a_ctrl)
                st_nxt.rdata = ctrl_byte(a_view);
            else if (sel_b_ctrl)
                st_nxt.rdata = ctrl_byte(b_view);
            else if (sel_a_mode)
                st_nxt.rdata = CMPREG_MODE_RSV_MASK | {2'h0, st_r.a_mode.rise_ie, st_r.a_mode.fall_ie,
                                                       2'h0, st_r.a_mode.md};
        end
        st_nxt.a_lat = a_level;
        st_nxt.b_lat = b_level;
        st_nxt.a_irq = ((a_rise_flag & st_r.a_mode.rise_ie) | (a_fall_flag & st_r.a_mode.fall_ie))
                       & CMP_A_SRC_IE & GLOBAL_IE;
        st_nxt.b_irq = (b_rise_flag | b_fall_flag) & CMP_B_SRC_IE & GLOBAL_IE;
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_r <= '0;
            st_r.a_mode.md <= CMPREG_MODE_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign CMP_A_ENABLE = st_r.a_en;
    assign CMP_B_ENABLE = st_r.b_en;
    assign CMP_A_POS_HYST = st_r.a_hyp;
    assign CMP_A_NEG_HYST = st_r.a_hyn;
    assign CMP_B_POS_HYST = st_r.b_hyp;
    assign CMP_B_NEG_HYST = st_r.b_hyn;
    assign CMP_A_RESPONSE_MODE = st_r.a_mode.md;
    assign CMP_A_LATCHED_OUTPUT = st_r.a_lat;
    assign CMP_B_LATCHED_OUTPUT = st_r.b_lat;
    assign CMP_A_IRQ = st_r.a_irq;
    assign CMP_B_IRQ = st_r.b_irq;
    assign SFR_RDATA = st_r.rdata;

    property p_en_write;
        @(posedge CLK) disable iff (!NRST) (SFR_WR && SFR_ADDR == 8'h9b && SFR_PAGE == 8'h00)
            |=> CMP_A_ENABLE == $past(SFR_WDATA[7]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable not taken from write");

    property p_page_only;
        @(posedge CLK) disable iff (!NRST) (SFR_WR && SFR_PAGE != 8'h00) |=> $stable(CMP_A_ENABLE);
    endproperty
    a_page_only: assert property (p_page_only) else $error("control written off page zero");

    property p_off_low;
        @(posedge CLK) disable iff (!NRST) (!CMP_A_ENABLE)[*4] |-> !a_level;
    endproperty
    a_off_low: assert property (p_off_low) else $error("disabled output not low");

    property p_mode_read;
        @(posedge CLK) disable iff (!NRST) (SFR_RD && SFR_ADDR == 8'h9d) |=> SFR_RDATA[7] && !SFR_RDATA[6]
            && SFR_RDATA[3:2] == 2'h0;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode fixed bits wrong");

    property p_mode_any_page;
        @(posedge CLK) disable iff (!NRST) (SFR_WR && SFR_ADDR == 8'h9d)
            |=> CMP_A_RESPONSE_MODE == $past(SFR_WDATA[1:0]);
    endproperty
    a_mode_any_page: assert property (p_mode_any_page) else $error("mode write missed");

    property p_irq;
        @(posedge CLK) disable iff (!NRST) CMP_A_IRQ |-> $past(GLOBAL_IE) && $past(CMP_A_SRC_IE)
            && (($past(a_rise_flag) && $past(st_r.a_mode.rise_ie))
            || ($past(a_fall_flag) && $past(st_r.a_mode.fall_ie)));
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");

    property p_state_bit;
        @(posedge CLK) disable iff (!NRST) (SFR_RD && SFR_ADDR == 8'h9a && SFR_PAGE == 8'h00)
            |=> SFR_RDATA[6] == $past(b_level);
    endproperty
    a_state_bit: assert property (p_state_bit) else $error("state bit wrong");

    property p_flag_free;
        @(posedge CLK) disable iff (!NRST) a_fall_ev |=> a_fall_flag;
    endproperty
    a_flag_free: assert property (p_flag_free) else $error("fall flag not set");

    sequence s_fall_event;
        a_fall_ev;
    endsequence

    sequence s_fall_armed;
        st_r.a_mode.fall_ie && CMP_A_SRC_IE && GLOBAL_IE;
    endsequence

    property p_fall_irq;
        @(posedge CLK) disable iff (!NRST) s_fall_event ##1 s_fall_armed |=> CMP_A_IRQ;
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("fall edge gave no request");

    property p_b_irq;
        @(posedge CLK) disable iff (!NRST) CMP_B_IRQ |-> $past(GLOBAL_IE) && $past(CMP_B_SRC_IE)
            && ($past(b_rise_flag) || $past(b_fall_flag));
    endproperty
    a_b_irq: assert property (p_b_irq) else $error("b irq without cause");
endmodule : cmpreg_top

/* File: inc/cmpreg_pkg.sv */
// package of comparator register constants and carrier types
package cmpreg_pkg;
    localparam logic [7:0] CMPREG_ADDR_B_CTRL = 8'h9a;
    localparam logic [7:0] CMPREG_ADDR_A_CTRL = 8'h9b;
    localparam logic [7:0] CMPREG_ADDR_A_MODE = 8'h9d;
    localparam logic [7:0] CMPREG_PAGE_CTRL = 8'h00;
    localparam int CMPREG_BIT_EN = 7;
    localparam int CMPREG_BIT_OUT = 6;
    localparam int CMPREG_BIT_RISE = 5;
    localparam int CMPREG_BIT_FALL = 4;
    localparam int CMPREG_BIT_RSV = 7;
    localparam logic [7:0] CMPREG_CTRL_RESET = 8'h00;
    localparam logic [1:0] CMPREG_HYST_RESET = 2'h0;
    localparam logic [1:0] CMPREG_MODE_RESET = 2'h2;
    localparam logic [7:0] CMPREG_MODE_RSV_MASK = 8'h80;
    localparam logic [7:0] CMPREG_MODE_UNUSED_MASK = 8'h4c;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] wdata;
        logic wr;
    } cmpreg_bus_t;

    typedef struct packed {
        logic en;
        logic out;
        logic rise;
        logic fall;
        logic [1:0] hyp;
        logic [1:0] hyn;
    } cmpreg_ctrl_t;

    typedef struct packed {
        logic rise_ie;
        logic fall_ie;
        logic [1:0] md;
    } cmpreg_mode_t;
endpackage : cmpreg_pkg

/* File: tb/cmpreg_analog_model.sv */
// behavioural model of the two analog comparators behind the registers
`timescale 1ns/1ps
module cmpreg_analog_model
(
    input wire logic en_a,
    input wire logic en_b,
    input wire logic vin_a,
    input wire logic vin_b,
    output logic raw_a,
    output logic raw_b
);
    // high when plus above minus, 0 in shutdown
    assign raw_a = en_a & vin_a;
    assign raw_b = en_b & vin_b;
endmodule : cmpreg_analog_model

/* File: tb/tb_cmpreg_top.sv */
// self-checking testbench for the comparator register block
`timescale 1ns/1ps
module tb_cmpreg_top;
    import cmpreg_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] page = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic raw_a, raw_b, en_a, en_b, lat_a, lat_b, irq_a, irq_b;
    logic src_a = 1'b1;
    logic src_b = 1'b1;
    logic gie = 1'b1;
    logic vin_a = 1'b0;
    logic vin_b = 1'b0;
    logic [1:0] hp_a, hn_a, hp_b, hn_b, md_a;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] r;
    int err_count = 0;
    int n_compared = 0;

    always #25 clk = ~clk;

    cmpreg_top u_cmpreg_top (.CLK(clk), .NRST(nrst), .SFR_ADDR(addr), .SFR_PAGE(page), .SFR_WDATA(wdata),
        .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_RDATA(rdata), .CMP_A_RAW(raw_a), .CMP_B_RAW(raw_b),
        .CMP_A_SRC_IE(src_a), .CMP_B_SRC_IE(src_b), .GLOBAL_IE(gie), .CMP_A_ENABLE(en_a),
        .CMP_B_ENABLE(en_b), .CMP_A_POS_HYST(hp_a), .CMP_A_NEG_HYST(hn_a), .CMP_B_POS_HYST(hp_b),
        .CMP_B_NEG_HYST(hn_b), .CMP_A_RESPONSE_MODE(md_a), .CMP_A_LATCHED_OUTPUT(lat_a),
        .CMP_B_LATCHED_OUTPUT(lat_b), .CMP_A_IRQ(irq_a), .CMP_B_IRQ(irq_b));

    cmpreg_analog_model u_cmpreg_analog_model (.en_a(en_a), .en_b(en_b), .vin_a(vin_a), .vin_b(vin_b),
        .raw_a(raw_a), .raw_b(raw_b));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        page = p;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        page = p;
        rd_s = 1'b1;
        exp_q.push_back(exp);
        @(negedge clk);
        rd_s = 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // read data monitor
    always @(posedge clk)
        rd_seen <= rd_s;
    always @(negedge clk)
    begin
        if (rd_seen)
        begin
            if (exp_q.size() == 0)
                chk(rdata, 8'hxx);
            else
                chk(rdata, exp_q.pop_front());
        end
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h780d9ebc));
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        vin_a = 1'b1;
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'h00);
        rd(CMPREG_ADDR_B_CTRL, 8'h00, 8'h00);
        rd(CMPREG_ADDR_A_MODE, 8'h00, 8'h82);
        chk({6'h0, md_a}, 8'h02);
        chk({7'h0, en_a}, 8'h00);
        $display("test reset values done");
        wr(CMPREG_ADDR_A_CTRL, 8'h00, 8'h80);
        idle(6);
        chk({6'h0, en_a, lat_a}, 8'h03);
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'he0);
        chk({7'h0, irq_a}, 8'h00);
        wr(CMPREG_ADDR_A_MODE, 8'h3c, 8'ha0);
        idle(2);
        chk({7'h0, irq_a}, 8'h01);
        gie = 1'b0;
        idle(2);
        chk({7'h0, irq_a}, 8'h00);
        gie = 1'b1;
        wr(CMPREG_ADDR_A_CTRL, 8'h00, 8'h80);
        idle(2);
        chk({7'h0, irq_a}, 8'h00);
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'hc0);
        vin_a = 1'b0;
        idle(6);
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'h90);
        chk({7'h0, irq_a}, 8'h00);
        wr(CMPREG_ADDR_A_MODE, 8'h00, 8'h90);
        idle(2);
        chk({7'h0, irq_a}, 8'h01);
        wr(CMPREG_ADDR_B_CTRL, 8'h00, 8'h80);
        vin_b = 1'b1;
        idle(7);
        chk({5'h0, en_b, lat_b, irq_b}, 8'h07);
        src_b = 1'b0;
        idle(2);
        chk({7'h0, irq_b}, 8'h00);
        vin_a = 1'b1;
        idle(1);
        wr(CMPREG_ADDR_A_CTRL, 8'h00, 8'h80);
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'he0);
        $display("test edges and requests done");
        vin_a = 1'b1;
        wr(CMPREG_ADDR_A_CTRL, 8'h00, 8'h00);
        wr(CMPREG_ADDR_B_CTRL, 8'h00, 8'h00);
        idle(6);
        chk({6'h0, en_a, lat_a}, 8'h00);
        chk({6'h0, en_b, lat_b}, 8'h00);
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'h10);
        $display("test shutdown done");
        for (int i = 0; i < 16; i++)
        begin
            wr(CMPREG_ADDR_A_CTRL, 8'h00, 8'(i));
            chk({4'h0, hp_a, hn_a}, 8'(i));
            rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'(i));
            r = 8'($urandom & 32'h0f);
            wr(CMPREG_ADDR_B_CTRL, 8'h00, r);
            chk({4'h0, hp_b, hn_b}, r);
            rd(CMPREG_ADDR_B_CTRL, 8'h00, r);
        end
        $display("test hysteresis done");
        wr(CMPREG_ADDR_A_CTRL, 8'h01, 8'h03);
        rd(CMPREG_ADDR_A_CTRL, 8'h00, 8'h0f);
        rd(CMPREG_ADDR_A_CTRL, 8'h01, 8'h00);
        rd(CMPREG_ADDR_B_CTRL, 8'h02, 8'h00);
        rd(8'h9c, 8'h00, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            r = 8'($urandom);
            wr(CMPREG_ADDR_A_MODE, r, 8'hcc | 8'(m));
            chk({6'h0, md_a}, 8'(m));
            rd(CMPREG_ADDR_A_MODE, ~r, 8'h80 | 8'(m));
        end
        $display("test pages and modes done");
        idle(2);
        chk(8'(exp_q.size()), 8'h00);
        complete_run();
    end
endmodule : tb_cmpreg_top
